// *** rtl/awsf_pkg.sv ***
package awsf_pkg;

	// number of watched quantities and flags per class
	localparam int NUM_QTY = 5;
	localparam int NUM_COND = 10;
	localparam int MEAS_W = 16;

	// quantity positions (ordering of the status bits, msb first)
	localparam int QTY_TEMP = 0;
	localparam int QTY_SUPPLY = 1;
	localparam int QTY_BIAS = 2;
	localparam int QTY_TXPWR = 3;
	localparam int QTY_RXPWR = 4;

	// status register selectors on the read port
	localparam logic [1:0] SEL_ALARM_0 = 2'h0;
	localparam logic [1:0] SEL_ALARM_1 = 2'h1;
	localparam logic [1:0] SEL_WARN_0 = 2'h2;
	localparam logic [1:0] SEL_WARN_1 = 2'h3;

	// field layout of the condition vector
	localparam int REG0_MSB = 9;
	localparam int REG0_LSB = 2;
	localparam int REG1_MSB = 1;
	localparam int REG1_LSB = 0;
	localparam int REG1_FILL_W = 6;

	// reset values
	localparam logic [NUM_COND-1:0] FLAGS_RESET = 10'h000;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef struct packed {
		logic [MEAS_W-1:0] temp;
		logic [MEAS_W-1:0] supply;
		logic [MEAS_W-1:0] bias;
		logic [MEAS_W-1:0] tx_power;
		logic [MEAS_W-1:0] rx_power;
	} awsf_meas_s;

	typedef struct packed {
		awsf_meas_s high;
		awsf_meas_s low;
	} awsf_limits_s;

	// open-drain pin: sampled level, driven value, enable
	typedef struct packed {
		logic in_lvl;
		logic out_lvl;
		logic oe;
	} awsf_od_pin_s;

endpackage

// *** rtl/awsf_status_flags.sv ***
// What this block does
// - twenty threshold conditions are watched, ten feeding the alarm registers and ten the warning registers.
// - alarm register 0 bits 7..0 hold temp/supply/bias/tx power high then low, alarm register 1 bits 7..6 rx power high and low.
// - warning registers 0 and 1 use the same bit order against the separate warning limits.
// - a true condition on a valid measurement sets its status bit; only a warm reset in the same cycle drops it.
// - a set bit holds until its register is read, power is cycled, a warm reset is requested or transmit disable is toggled.
// - while transmit disable is asserted evaluation and reporting go on exactly as normal.
// - on release of transmit disable every alarm and warning bit is cleared.
// - receive loss, rate select and transmit fault are driven through open-drain outputs only.
// - the status bits of those lines report the level sampled at the pins.
// - a warm reset deasserts transmit fault and receive loss, restores all state but the abort flag to power-on values and aborts a conversion.
`timescale 1ns/100ps
`default_nettype none

module awsf_status_flags (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic meas_valid,
	input wire awsf_pkg::awsf_meas_s meas,
	input wire awsf_pkg::awsf_limits_s alarm_limits,
	input wire awsf_pkg::awsf_limits_s warn_limits,
	input wire logic rd_stb,
	input wire logic [1:0] rd_sel,
	output logic [7:0] rd_data,
	output logic rd_ack,
	input wire logic transmit_disable_pin,
	input wire logic warm_reset_req,
	output logic conv_abort,
	input wire logic rx_loss_req,
	input wire logic tx_fault_req,
	input wire logic rate_select_ctl,
	input wire logic receive_loss_line_in,
	output logic receive_loss_line_out,
	output logic receive_loss_line_oe,
	input wire logic transmit_fault_line_in,
	output logic transmit_fault_line_out,
	output logic transmit_fault_line_oe,
	input wire logic rate_select_line_in,
	output logic rate_select_line_out,
	output logic rate_select_line_oe,
	output logic rx_loss_status,
	output logic tx_fault_status,
	output logic rate_select_status
);
	import awsf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [NUM_COND-1:0] alarm;
		logic [NUM_COND-1:0] warn;
		logic [7:0] rdata;
		logic ack;
		logic abort;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic txdis_prev;
		logic drive_rx_loss;
		logic drive_tx_fault;
		logic drive_rate_sel;
	} awsf_state_s;

	awsf_state_s st_r;
	awsf_state_s st_nxt;

	localparam awsf_state_s ST_RESET = '{
		alarm: FLAGS_RESET,
		warn: FLAGS_RESET,
		rdata: RDATA_RESET,
		ack: 1'b0,
		abort: 1'b0,
		sync1: 4'h0,
		sync2: 4'h0,
		txdis_prev: 1'b0,
		drive_rx_loss: 1'b0,
		drive_tx_fault: 1'b0,
		drive_rate_sel: 1'b0
	};

	////////////////////////////////////////////////////////////////////////
	// threshold compare

	function automatic logic [MEAS_W-1:0] pick(input awsf_meas_s m,
		input int q);
		logic [MEAS_W-1:0] v;
		v = m.temp;
		unique case (q)
			QTY_TEMP: v = m.temp;
			QTY_SUPPLY: v = m.supply;
			QTY_BIAS: v = m.bias;
			QTY_TXPWR: v = m.tx_power;
			QTY_RXPWR: v = m.rx_power;
			default: v = m.temp;
		endcase
		return v;
	endfunction

	// temperature is two's complement, the other quantities are unsigned
	function automatic logic above(input logic [MEAS_W-1:0] a,
		input logic [MEAS_W-1:0] b, input logic is_signed);
		logic r;
		r = is_signed ? ($signed(a) > $signed(b)) : (a > b);
		return r;
	endfunction

	logic [NUM_COND-1:0] alarm_cond;
	logic [NUM_COND-1:0] warn_cond;

	genvar q;
	generate
		for (q = 0; q < NUM_QTY; q++) begin : g_qty
			localparam int HI = REG0_MSB - 2 * q;
			localparam int LO = REG0_MSB - 2 * q - 1;
			localparam logic SGN = (q == QTY_TEMP);
			logic [MEAS_W-1:0] m;
			assign m = pick(meas, q);
			assign alarm_cond[HI] = above(m, pick(alarm_limits.high, q), SGN);
			assign alarm_cond[LO] = above(pick(alarm_limits.low, q), m, SGN);
			assign warn_cond[HI] = above(m, pick(warn_limits.high, q), SGN);
			assign warn_cond[LO] = above(pick(warn_limits.low, q), m, SGN);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next state

	logic txdis_s;
	logic txdis_fall;
	logic [NUM_COND-1:0] alarm_set;
	logic [NUM_COND-1:0] warn_set;
	logic [NUM_COND-1:0] alarm_clr;
	logic [NUM_COND-1:0] warn_clr;

	always_comb begin
		st_nxt = st_r;
		alarm_clr = '0;
		warn_clr = '0;
		txdis_s = st_r.sync2[3];
		txdis_fall = st_r.txdis_prev & ~txdis_s;
		// evaluation is independent of transmit disable
		alarm_set = meas_valid ? alarm_cond : '0;
		warn_set = meas_valid ? warn_cond : '0;
		st_nxt.sync1 = {transmit_disable_pin, rate_select_line_in,
			transmit_fault_line_in, receive_loss_line_in};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.txdis_prev = txdis_s;
		st_nxt.ack = rd_stb;
		st_nxt.abort = 1'b0;
		if (rd_stb) begin
			unique case (rd_sel)
				SEL_ALARM_0: begin
					st_nxt.rdata = st_r.alarm[REG0_MSB:REG0_LSB];
					alarm_clr[REG0_MSB:REG0_LSB] = '1;
				end
				SEL_ALARM_1: begin
					st_nxt.rdata = {st_r.alarm[REG1_MSB:REG1_LSB],
						{REG1_FILL_W{1'b0}}};
					alarm_clr[REG1_MSB:REG1_LSB] = '1;
				end
				SEL_WARN_0: begin
					st_nxt.rdata = st_r.warn[REG0_MSB:REG0_LSB];
					warn_clr[REG0_MSB:REG0_LSB] = '1;
				end
				SEL_WARN_1: begin
					st_nxt.rdata = {st_r.warn[REG1_MSB:REG1_LSB],
						{REG1_FILL_W{1'b0}}};
					warn_clr[REG1_MSB:REG1_LSB] = '1;
				end
			endcase
		end
		if (txdis_fall) begin
			alarm_clr = '1;
			warn_clr = '1;
		end
		// clears first, then sets: an event in the clearing cycle survives
		st_nxt.alarm = (st_r.alarm & ~alarm_clr) | alarm_set;
		st_nxt.warn = (st_r.warn & ~warn_clr) | warn_set;
		st_nxt.drive_rx_loss = rx_loss_req;
		st_nxt.drive_tx_fault = tx_fault_req;
		st_nxt.drive_rate_sel = rate_select_ctl;
		if (warm_reset_req) begin
			// a pending measurement is dropped, not evaluated
			st_nxt = ST_RESET;
			st_nxt.abort = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign rd_data = st_r.rdata;
	assign rd_ack = st_r.ack;
	assign conv_abort = st_r.abort;

	// lines are asserted high by the external pull-up; only pull low
	assign receive_loss_line_out = 1'b0;
	assign receive_loss_line_oe = ~st_r.drive_rx_loss;
	assign transmit_fault_line_out = 1'b0;
	assign transmit_fault_line_oe = ~st_r.drive_tx_fault;
	assign rate_select_line_out = 1'b0;
	assign rate_select_line_oe = ~st_r.drive_rate_sel;

	// pin levels, whoever drives them
	assign rx_loss_status = st_r.sync2[0];
	assign tx_fault_status = st_r.sync2[1];
	assign rate_select_status = st_r.sync2[2];

endmodule // awsf_status_flags

`default_nettype wire

// *** tb/awsf_status_flags_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module awsf_status_flags_monitor (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic meas_valid,
	input wire logic rd_stb,
	input wire logic [1:0] rd_sel,
	input wire logic [7:0] rd_data,
	input wire logic rd_ack,
	input wire logic warm_reset_req,
	input wire logic conv_abort,
	input wire logic rx_loss_req,
	input wire logic tx_fault_req,
	input wire logic receive_loss_line_in,
	input wire logic receive_loss_line_out,
	input wire logic receive_loss_line_oe,
	input wire logic transmit_fault_line_out,
	input wire logic transmit_fault_line_oe,
	input wire logic rate_select_line_out,
	input wire logic rx_loss_status
);
	import awsf_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// gap of one cycle matches the host model's spacing
	sequence warm_then_read;
		warm_reset_req ##1 !meas_valid ##1 (rd_stb && !warm_reset_req);
	endsequence
	sequence read_twice;
		(rd_stb && !meas_valid && !warm_reset_req)
		##1 (!meas_valid && !warm_reset_req)
		##1 (rd_stb && !warm_reset_req && rd_sel == $past(rd_sel, 2));
	endsequence
	ack_timing_a: assert property (rd_stb && !warm_reset_req
		|=> rd_ack)
		else $error("read not acknowledged one cycle later");
	od_low_only_a: assert property (!(receive_loss_line_out ||
		transmit_fault_line_out || rate_select_line_out))
		else $error("open-drain line driven high");
	loss_line_a: assert property (!warm_reset_req |=>
		receive_loss_line_oe != $past(rx_loss_req))
		else $error("receive loss pull-down not following request");
	fault_line_a: assert property (!warm_reset_req |=>
		transmit_fault_line_oe != $past(tx_fault_req))
		else $error("transmit fault pull-down not following request");
	warm_abort_a: assert property (warm_reset_req |=> conv_abort &&
		receive_loss_line_oe && transmit_fault_line_oe)
		else $error("warm reset did not abort and deassert lines");
	warm_clear_a: assert property (warm_then_read
		|=> rd_data == 8'h00)
		else $error("flags survived warm reset");
	pin_status_a: assert property ((!warm_reset_req &&
		receive_loss_line_in == $past(receive_loss_line_in))[*5]
		|-> rx_loss_status == receive_loss_line_in)
		else $error("status differs from pin level");
	read_clear_a: assert property (read_twice |=> rd_data == 8'h00)
		else $error("second read returned uncleared bits");
	reg1_fill_a: assert property (rd_stb && rd_sel[0]
		&& !warm_reset_req |=> rd_data[5:0] == 6'h00)
		else $error("unused bits of register one not zero");
endmodule // awsf_status_flags_monitor
////////////////////////////////////////
bind awsf_status_flags awsf_status_flags_monitor
	i_awsf_status_flags_monitor (.*);
`default_nettype wire

// *** tb/awsf_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module awsf_host_model (
	input wire logic core_clk,
	input wire logic rd_ack,
	input wire logic [7:0] rd_data,
	output var logic rd_stb,
	output var logic [1:0] rd_sel
);
	initial begin
		rd_stb = 1'b0;
		rd_sel = 2'h0;
	end
	// strobe is one cycle wide: holding it would start a second read
	task automatic access(input logic [1:0] sel, output logic [7:0] data,
		output bit ok);
		ok = 1'b0;
		data = 8'h00;
		@(posedge core_clk);
		#2;
		rd_stb = 1'b1;
		rd_sel = sel;
		@(posedge core_clk);
		#2;
		rd_stb = 1'b0;
		rd_sel = ~sel;
		repeat (4) begin
			if (!ok && rd_ack === 1'b1) begin
				data = rd_data;
				ok = 1'b1;
			end
			if (!ok) begin
				@(posedge core_clk);
				#2;
			end
		end
	endtask
endmodule // awsf_host_model
`default_nettype wire

// *** tb/awsf_status_flags_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module awsf_status_flags_bench;
	import awsf_pkg::*;
	logic core_clk, reset, meas_valid, rd_stb, rd_ack, warm_reset_req;
	logic conv_abort, rx_loss_req, tx_fault_req, rate_select_ctl, ext_low;
	logic transmit_disable_pin, rx_loss_status, tx_fault_status;
	logic rate_select_status, receive_loss_line_out, receive_loss_line_oe;
	logic transmit_fault_line_out, transmit_fault_line_oe;
	logic rate_select_line_out, rate_select_line_oe;
	logic [1:0] rd_sel;
	logic [7:0] rd_data;
	awsf_meas_s meas;
	awsf_limits_s alarm_limits, warn_limits;
	wire logic receive_loss_line_in, transmit_fault_line_in, rate_select_line_in;
	int failures, total_checks;
	// pull-ups; the block or an outside driver may pull each line low
	assign receive_loss_line_in = !((receive_loss_line_oe &&
		!receive_loss_line_out) || ext_low);
	assign transmit_fault_line_in = !((transmit_fault_line_oe &&
		!transmit_fault_line_out) || ext_low);
	assign rate_select_line_in = !((rate_select_line_oe &&
		!rate_select_line_out) || ext_low);
	awsf_status_flags i_awsf_status_flags (.*);
	awsf_host_model i_awsf_host_model (.*);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic rd_chk(input logic [1:0] sel, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		i_awsf_host_model.access(sel, d, ok);
		if (!ok) begin
			failures++;
			wrap_up();
		end else chk(d, exp);
	endtask
	task automatic pulse(input int q, input logic [15:0] v);
		meas[79-16*q -: 16] = v;
		meas_valid = 1'b1;
		cyc(1);
		meas_valid = 1'b0;
		meas = {5{16'h2800}};
	endtask
	initial begin
		logic [7:0] e;
		logic [1:0] s;
		logic [7:0] p;
		failures = 0;
		total_checks = 0;
		meas_valid = 1'b0;
		meas = {5{16'h2800}};
		alarm_limits = {{5{16'h4000}}, {5{16'h1000}}};
		warn_limits = {{5{16'h3000}}, {5{16'h2000}}};
		{warm_reset_req, transmit_disable_pin, ext_low} = 3'h0;
		{rx_loss_req, tx_fault_req, rate_select_ctl} = 3'h0;
		reset = 1'b1;
		cyc(16);
		reset = 1'b0;
		for (int i = 0; i < 4; i++)
			rd_chk(2'(i), RDATA_RESET);
		for (int q = 0; q < NUM_QTY; q++) begin
			for (int h = 0; h < 2; h++) begin
				pulse(q, h ? 16'h0800 : 16'h5000);
				e = 8'h80 >> (q == QTY_RXPWR ? h : 2 * q + h);
				s = (q == QTY_RXPWR) ? SEL_ALARM_1 : SEL_ALARM_0;
				rd_chk(s, e); // alarm bit
				rd_chk(s, 8'h00); // cleared by read
				rd_chk(s + 2'h2, e); // warning untouched
				rd_chk(s + 2'h2, 8'h00); // warning cleared
			end
		end
		transmit_disable_pin = 1'b1;
		cyc(4);
		pulse(QTY_TEMP, 16'h5000);
		rd_chk(SEL_ALARM_0, 8'h80); // flags while disabled
		pulse(QTY_TEMP, 16'h5000);
		pulse(QTY_SUPPLY, 16'h1800);
		transmit_disable_pin = 1'b0;
		cyc(6);
		rd_chk(SEL_ALARM_0, 8'h00); // cleared on release
		rd_chk(SEL_WARN_0, 8'h00); // cleared on release
		{rx_loss_req, tx_fault_req, rate_select_ctl} = 3'h7;
		cyc(6);
		p = {5'h00, rx_loss_status, tx_fault_status, rate_select_status};
		chk(p, 8'h07);
		ext_low = 1'b1;
		cyc(6);
		p = {5'h00, rx_loss_status, tx_fault_status, rate_select_status};
		chk(p, 8'h00);
		ext_low = 1'b0;
		pulse(QTY_TEMP, 16'h5000);
		warm_reset_req = 1'b1;
		cyc(1);
		chk({7'h00, conv_abort}, 8'h01); // abort pulse
		warm_reset_req = 1'b0;
		rd_chk(SEL_ALARM_0, RDATA_RESET); // flags restored
		wrap_up();
	end
endmodule // awsf_status_flags_bench
`default_nettype wire
